// [logic/rss_alu_top.sv]
// rss_alu_top: rotate, subtract, skip and set datapath slice with flags
`timescale 1ns/100ps
module rss_alu_top (
	// clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       rst_in,
	// instruction issue
	input  wire logic       issue_in,
	input  wire logic [4:0] op_in,
	input  wire logic [7:0] operand_in,
	input  wire logic [2:0] bit_sel_in,
	// results
	output logic [7:0]      working_register_out,
	output logic [7:0]      mem_wdata_out,
	output logic            mem_we_out,
	output logic            carry_flag_out,
	output logic            half_borrow_flag_out,
	output logic            zero_flag_out,
	output logic            signed_wrap_flag_out,
	output logic            dummy_cycle_out,
	output logic            ready_out
);
	typedef enum {RSS_RUN, RSS_DUMMY} rss_state_t;

	rss_alu_if  a ();
	rss_state_t state;
	rss_state_t next_state;
	logic [7:0] working_register;
	logic [7:0] next_working_register;
	logic [3:0] flags;
	logic [3:0] next_flags;
	logic [7:0] mem_wdata;
	logic [7:0] next_mem_wdata;
	logic       mem_we;
	logic       next_mem_we;
	logic       take;

	rss_alu_core u_core (
		.a (a)
	);

	// ==========================================
	// operand steering
	assign a.op        = take ? op_in : rss_pkg::OP_NONE;
	assign a.work      = working_register;
	assign a.operand   = (op_in == rss_pkg::OP_SUB_IMM) ? operand_in : operand_in;
	assign a.bit_sel   = bit_sel_in;
	assign a.flags_old = flags;
	// issue is ignored during the dummy cycle of a taken skip
	assign take        = issue_in && (state == RSS_RUN);

	// ==========================================
	// next state
	always_comb begin
		next_state            = state;
		next_working_register = working_register;
		next_flags            = flags;
		next_mem_wdata        = mem_wdata;
		next_mem_we           = 1'b0;
		case (state)
			RSS_RUN: begin
				if (take) begin
					next_flags = a.flags_new;
					if (a.to_work) begin
						next_working_register = a.result;
					end
					if (a.to_mem) begin
						next_mem_wdata = a.result;
						next_mem_we    = 1'b1;
					end
					if (a.skip) begin
						next_state = RSS_DUMMY;
					end
				end
			end
			RSS_DUMMY: begin
				next_state = RSS_RUN;
			end
			default: begin
				next_state = RSS_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state            <= RSS_RUN;
			working_register <= rss_pkg::WORK_RST;
			flags            <= rss_pkg::FLAGS_RST;
			mem_wdata        <= rss_pkg::WORK_RST;
			mem_we           <= 1'b0;
		end else begin
			state            <= next_state;
			working_register <= next_working_register;
			flags            <= next_flags;
			mem_wdata        <= next_mem_wdata;
			mem_we           <= next_mem_we;
		end
	end

	// ==========================================
	// outputs from flops; dummy_cycle_out and ready_out are decoded from state
	assign working_register_out = working_register;
	assign mem_wdata_out        = mem_wdata;
	assign mem_we_out           = mem_we;
	assign carry_flag_out       = flags[rss_pkg::FLAG_CARRY];
	assign half_borrow_flag_out = flags[rss_pkg::FLAG_HALF];
	assign zero_flag_out        = flags[rss_pkg::FLAG_ZERO];
	assign signed_wrap_flag_out = flags[rss_pkg::FLAG_WRAP];
	assign dummy_cycle_out      = (state == RSS_DUMMY);
	assign ready_out            = (state == RSS_RUN);

	// ==========================================
	// assertions
	a_rot_left_carry: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(take && op_in == rss_pkg::OP_ROT_L_FLAG_WORK) |=>
		working_register == {$past(operand_in[6:0]), $past(flags[0])} &&
		flags[0] == $past(operand_in[7]) && !mem_we)
		else $error("left rotate through carry wrong");
	a_rot_right_mem: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(take && op_in == rss_pkg::OP_ROT_R) |=>
		mem_we && mem_wdata == {$past(operand_in[0]), $past(operand_in[7:1])} && $stable(flags))
		else $error("right rotate memory wrong");
	a_rot_right_work: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(take && op_in == rss_pkg::OP_ROT_R_WORK) |=>
		!mem_we && working_register == {$past(operand_in[0]), $past(operand_in[7:1])})
		else $error("right rotate to working wrong");
	a_rot_right_carry: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(take && op_in == rss_pkg::OP_ROT_R_FLAG) |=>
		mem_we && mem_wdata == {$past(flags[0]), $past(operand_in[7:1])} &&
		flags[0] == $past(operand_in[0]))
		else $error("right rotate through carry wrong");
	a_rot_carry_work: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(take && op_in == rss_pkg::OP_ROT_R_FLAG_WORK) |=>
		!mem_we && flags[3:1] == $past(flags[3:1]))
		else $error("carry rotate touched other flags");
	a_sub_carry: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(take && op_in == rss_pkg::OP_SUB_WORK) |=>
		flags[0] == ($past(working_register) >= $past(operand_in)))
		else $error("subtract carry wrong");
	a_sub_borrow: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(take && op_in == rss_pkg::OP_SUB_BORROW_WORK) |=>
		working_register == 8'($past(working_register) - $past(operand_in) -
		{7'h00, ~$past(flags[0])}))
		else $error("subtract with borrow wrong");
	a_skip_dummy: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(take && op_in == rss_pkg::OP_SKIP_WHEN_ZERO && operand_in == 8'h00) |=>
		dummy_cycle_out ##1 ready_out)
		else $error("taken skip lacks one dummy cycle");
	a_bit_set_mem: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(take && op_in == rss_pkg::OP_BIT_SET) |=>
		mem_we && mem_wdata[$past(bit_sel_in)] && $stable(flags))
		else $error("bit set wrong");
	a_inc_skip: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(take && op_in == rss_pkg::OP_INC_SKIP_ZERO) |=>
		mem_wdata == 8'($past(operand_in) + 8'h01) && dummy_cycle_out == (mem_wdata == 8'h00))
		else $error("increment skip wrong");
	c_skip_taken: cover property (@(posedge ref_clk_in) disable iff (rst_in) dummy_cycle_out);
	c_sub_neg: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		take && op_in == rss_pkg::OP_SUB_MEM ##1 !carry_flag_out);
	c_wrap: cover property (@(posedge ref_clk_in) disable iff (rst_in) signed_wrap_flag_out);
endmodule // rss_alu_top

// [logic/rss_pkg.sv]
// rss_pkg: opcodes, flag positions and reset values for the rotate/subtract/skip slice
package rss_pkg;
	localparam int DATA_W = 8;
	localparam int OP_W   = 5;
	localparam int BIT_W  = 3;

	// ==========================================
	// operation codes
	localparam logic [4:0] OP_NONE               = 5'h00;
	localparam logic [4:0] OP_ROT_L_FLAG_WORK    = 5'h01;
	localparam logic [4:0] OP_ROT_R              = 5'h02;
	localparam logic [4:0] OP_ROT_R_WORK         = 5'h03;
	localparam logic [4:0] OP_ROT_R_FLAG         = 5'h04;
	localparam logic [4:0] OP_ROT_R_FLAG_WORK    = 5'h05;
	localparam logic [4:0] OP_SUB_BORROW_WORK    = 5'h06;
	localparam logic [4:0] OP_SUB_BORROW_MEM     = 5'h07;
	localparam logic [4:0] OP_SUB_WORK           = 5'h08;
	localparam logic [4:0] OP_SUB_MEM            = 5'h09;
	localparam logic [4:0] OP_SUB_IMM            = 5'h0A;
	localparam logic [4:0] OP_DEC_SKIP_ZERO      = 5'h0B;
	localparam logic [4:0] OP_DEC_SKIP_ZERO_WORK = 5'h0C;
	localparam logic [4:0] OP_INC_SKIP_ZERO      = 5'h0D;
	localparam logic [4:0] OP_INC_SKIP_ZERO_WORK = 5'h0E;
	localparam logic [4:0] OP_SKIP_BIT_SET       = 5'h0F;
	localparam logic [4:0] OP_SKIP_WHEN_ZERO     = 5'h10;
	localparam logic [4:0] OP_BYTE_SET           = 5'h11;
	localparam logic [4:0] OP_BIT_SET            = 5'h12;
	localparam logic [4:0] OP_NIBBLE_EXCH        = 5'h13;
	localparam logic [4:0] OP_NIBBLE_EXCH_WORK   = 5'h14;

	// ==========================================
	// flag vector positions
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_HALF  = 1;
	localparam int FLAG_ZERO  = 2;
	localparam int FLAG_WRAP  = 3;

	// ==========================================
	// reset values and the all-ones byte set value
	localparam logic [7:0] WORK_RST  = 8'h00;
	localparam logic [3:0] FLAGS_RST = 4'h0;
	localparam logic [7:0] ALL_ONES  = 8'hFF;
endpackage

// [logic/rss_alu_if.sv]
// rss_alu_if: bundle between the sequencer and the combinational alu core
`timescale 1ns/100ps
interface rss_alu_if;
	logic [4:0] op;
	logic [7:0] work;
	logic [7:0] operand;
	logic [2:0] bit_sel;
	logic [3:0] flags_old;
	logic [7:0] result;
	logic [3:0] flags_new;
	logic       to_work;
	logic       to_mem;
	logic       skip;
	modport core (input op, work, operand, bit_sel, flags_old,
		output result, flags_new, to_work, to_mem, skip);
	modport seq (output op, work, operand, bit_sel, flags_old,
		input result, flags_new, to_work, to_mem, skip);
endinterface

// [logic/rss_alu_core.sv]
// rss_alu_core: combinational result, flag and skip generation
`timescale 1ns/100ps
module rss_alu_core (
	rss_alu_if.core a
);
	// ==========================================
	// subtract helper: work - b - borrow, returns {c,h,z,v,result}
	function automatic logic [11:0] sub_f(input logic [7:0] x, input logic [7:0] y,
		input logic bi);
		logic [8:0] d;
		logic [4:0] lo;
		logic       v;
		d  = {1'b0, x} - {1'b0, y} - {8'h00, bi};
		lo = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, bi};
		v  = (x[7] ^ y[7]) & (x[7] ^ d[7]);
		sub_f = {~d[8], ~lo[4], (d[7:0] == 8'h00), v, d[7:0]};
	endfunction

	logic [11:0] s;
	logic [7:0]  one_hot;

	always_comb begin
		s         = 12'h000;
		one_hot   = 8'h01 << a.bit_sel;
		a.result  = a.operand;
		a.flags_new = a.flags_old;
		a.to_work = 1'b0;
		a.to_mem  = 1'b0;
		a.skip    = 1'b0;
		case (a.op)
			rss_pkg::OP_ROT_L_FLAG_WORK: begin
				a.result = {a.operand[6:0], a.flags_old[rss_pkg::FLAG_CARRY]};
				a.flags_new[rss_pkg::FLAG_CARRY] = a.operand[7];
				a.to_work = 1'b1;
			end
			rss_pkg::OP_ROT_R: begin
				a.result = {a.operand[0], a.operand[7:1]};
				a.to_mem = 1'b1;
			end
			rss_pkg::OP_ROT_R_WORK: begin
				a.result = {a.operand[0], a.operand[7:1]};
				a.to_work = 1'b1;
			end
			rss_pkg::OP_ROT_R_FLAG, rss_pkg::OP_ROT_R_FLAG_WORK: begin
				a.result = {a.flags_old[rss_pkg::FLAG_CARRY], a.operand[7:1]};
				a.flags_new[rss_pkg::FLAG_CARRY] = a.operand[0];
				a.to_mem  = (a.op == rss_pkg::OP_ROT_R_FLAG);
				a.to_work = (a.op == rss_pkg::OP_ROT_R_FLAG_WORK);
			end
			rss_pkg::OP_SUB_BORROW_WORK, rss_pkg::OP_SUB_BORROW_MEM,
			rss_pkg::OP_SUB_WORK, rss_pkg::OP_SUB_MEM, rss_pkg::OP_SUB_IMM: begin
				// borrow in is the inverted carry, only for the borrow variants
				s = sub_f(a.work, a.operand,
					((a.op == rss_pkg::OP_SUB_BORROW_WORK) ||
					 (a.op == rss_pkg::OP_SUB_BORROW_MEM)) &
					~a.flags_old[rss_pkg::FLAG_CARRY]);
				a.result = s[7:0];
				a.flags_new[rss_pkg::FLAG_CARRY] = s[11];
				a.flags_new[rss_pkg::FLAG_HALF]  = s[10];
				a.flags_new[rss_pkg::FLAG_ZERO]  = s[9];
				a.flags_new[rss_pkg::FLAG_WRAP]  = s[8];
				a.to_mem  = (a.op == rss_pkg::OP_SUB_BORROW_MEM) ||
					(a.op == rss_pkg::OP_SUB_MEM);
				a.to_work = ~a.to_mem;
			end
			rss_pkg::OP_DEC_SKIP_ZERO, rss_pkg::OP_DEC_SKIP_ZERO_WORK: begin
				a.result  = a.operand - 8'h01;
				a.skip    = (a.result == 8'h00);
				a.to_mem  = (a.op == rss_pkg::OP_DEC_SKIP_ZERO);
				a.to_work = ~a.to_mem;
			end
			rss_pkg::OP_INC_SKIP_ZERO, rss_pkg::OP_INC_SKIP_ZERO_WORK: begin
				a.result  = a.operand + 8'h01;
				a.skip    = (a.result == 8'h00);
				a.to_mem  = (a.op == rss_pkg::OP_INC_SKIP_ZERO);
				a.to_work = ~a.to_mem;
			end
			rss_pkg::OP_SKIP_BIT_SET: begin
				a.skip = |(a.operand & one_hot);
			end
			rss_pkg::OP_SKIP_WHEN_ZERO: begin
				a.skip = (a.operand == 8'h00);
			end
			rss_pkg::OP_BYTE_SET: begin
				a.result = rss_pkg::ALL_ONES;
				a.to_mem = 1'b1;
			end
			rss_pkg::OP_BIT_SET: begin
				a.result = a.operand | one_hot;
				a.to_mem = 1'b1;
			end
			rss_pkg::OP_NIBBLE_EXCH, rss_pkg::OP_NIBBLE_EXCH_WORK: begin
				a.result  = {a.operand[3:0], a.operand[7:4]};
				a.to_mem  = (a.op == rss_pkg::OP_NIBBLE_EXCH);
				a.to_work = ~a.to_mem;
			end
			default: begin
				a.result = a.operand;
			end
		endcase
	end
endmodule // rss_alu_core

// [dv/tb_top.sv]
// tb_top: self-checking bench for the rotate, subtract, skip and set datapath slice
`timescale 1ns/100ps
module tb_top;
	// ==========================================
	// signals
	logic       ref_clk_in;
	logic       rst_in;
	logic       issue_in;
	logic [4:0] op_in;
	logic [7:0] operand_in;
	logic [2:0] bit_sel_in;
	logic [7:0] working_register_out;
	logic [7:0] mem_wdata_out;
	logic       mem_we_out;
	logic       carry_flag_out;
	logic       half_borrow_flag_out;
	logic       zero_flag_out;
	logic       signed_wrap_flag_out;
	logic       dummy_cycle_out;
	logic       ready_out;
	int         error_cnt;
	int         check_count;
	int         cycle_cnt;

	rss_alu_top i_dut (
		.ref_clk_in           (ref_clk_in),
		.rst_in               (rst_in),
		.issue_in             (issue_in),
		.op_in                (op_in),
		.operand_in           (operand_in),
		.bit_sel_in           (bit_sel_in),
		.working_register_out (working_register_out),
		.mem_wdata_out        (mem_wdata_out),
		.mem_we_out           (mem_we_out),
		.carry_flag_out       (carry_flag_out),
		.half_borrow_flag_out (half_borrow_flag_out),
		.zero_flag_out        (zero_flag_out),
		.signed_wrap_flag_out (signed_wrap_flag_out),
		.dummy_cycle_out      (dummy_cycle_out),
		.ready_out            (ready_out)
	);

	always #50 ref_clk_in = ~ref_clk_in;

	// ==========================================
	// checking and closing
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks=%0d errors=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// guards against a hang: fails and ends the run once 1000 clock cycles have passed
	always @(posedge ref_clk_in) begin
		cycle_cnt++;
		if (cycle_cnt >= 1000) begin
			error_cnt++;
			summarize();
		end
	end

	// ==========================================
	// one instruction; f is {wrap, zero, half, carry}
	task automatic do_op(input logic [4:0] op, input logic [7:0] x, input logic [2:0] b,
			input logic [7:0] w, input logic [7:0] md, input logic we, input logic sk,
			input logic [3:0] f);
		@(posedge ref_clk_in);
		op_in <= op;
		operand_in <= x;
		bit_sel_in <= b;
		issue_in <= 1'h1;
		@(posedge ref_clk_in);
		issue_in <= 1'h0;
		#1;
		chk(working_register_out, w);
		chk({7'h00, mem_we_out}, {7'h00, we});
		if (we) chk(mem_wdata_out, md);
		chk({4'h0, signed_wrap_flag_out, zero_flag_out, half_borrow_flag_out,
			carry_flag_out}, {4'h0, f});
		chk({6'h00, dummy_cycle_out, ready_out}, {6'h00, sk, !sk});
		// a taken skip must cost exactly one extra cycle
		if (sk) begin
			@(posedge ref_clk_in);
			#1;
			chk({6'h00, dummy_cycle_out, ready_out}, 8'h01);
		end
	endtask

	// ==========================================
	// scenarios
	task automatic t_rotate();
		do_op(rss_pkg::OP_ROT_L_FLAG_WORK, 8'h81, 3'h0, 8'h02, 8'h00, 0, 0, 4'h1);
		do_op(rss_pkg::OP_ROT_R_FLAG_WORK, 8'h02, 3'h0, 8'h81, 8'h00, 0, 0, 4'h0);
		do_op(rss_pkg::OP_ROT_R_FLAG, 8'h01, 3'h0, 8'h81, 8'h00, 1, 0, 4'h1);
		do_op(rss_pkg::OP_ROT_R, 8'h01, 3'h0, 8'h81, 8'h80, 1, 0, 4'h1);
		do_op(rss_pkg::OP_ROT_R_WORK, 8'h06, 3'h0, 8'h03, 8'h00, 0, 0, 4'h1);
	endtask

	task automatic t_subtract();
		do_op(rss_pkg::OP_NIBBLE_EXCH_WORK, 8'h05, 3'h0, 8'h50, 8'h00, 0, 0, 4'h1);
		do_op(rss_pkg::OP_SUB_WORK, 8'h10, 3'h0, 8'h40, 8'h00, 0, 0, 4'h3);
		do_op(rss_pkg::OP_SUB_IMM, 8'h41, 3'h0, 8'hFF, 8'h00, 0, 0, 4'h0);
		do_op(rss_pkg::OP_SUB_BORROW_WORK, 8'h0F, 3'h0, 8'hEF, 8'h00, 0, 0, 4'h1);
		do_op(rss_pkg::OP_SUB_MEM, 8'hEF, 3'h0, 8'hEF, 8'h00, 1, 0, 4'h7);
		do_op(rss_pkg::OP_NIBBLE_EXCH_WORK, 8'h08, 3'h0, 8'h80, 8'h00, 0, 0, 4'h7);
		do_op(rss_pkg::OP_SUB_BORROW_MEM, 8'h01, 3'h0, 8'h80, 8'h7F, 1, 0, 4'h9);
	endtask

	task automatic t_skip();
		do_op(rss_pkg::OP_DEC_SKIP_ZERO, 8'h01, 3'h0, 8'h80, 8'h00, 1, 1, 4'h9);
		do_op(rss_pkg::OP_DEC_SKIP_ZERO, 8'h05, 3'h0, 8'h80, 8'h04, 1, 0, 4'h9);
		do_op(rss_pkg::OP_DEC_SKIP_ZERO_WORK, 8'h01, 3'h0, 8'h00, 8'h00, 0, 1, 4'h9);
		do_op(rss_pkg::OP_INC_SKIP_ZERO, 8'hFF, 3'h0, 8'h00, 8'h00, 1, 1, 4'h9);
		do_op(rss_pkg::OP_INC_SKIP_ZERO_WORK, 8'h7F, 3'h0, 8'h80, 8'h00, 0, 0, 4'h9);
		do_op(rss_pkg::OP_INC_SKIP_ZERO_WORK, 8'hFF, 3'h0, 8'h00, 8'h00, 0, 1, 4'h9);
		do_op(rss_pkg::OP_SKIP_BIT_SET, 8'h08, 3'h3, 8'h00, 8'h00, 0, 1, 4'h9);
		do_op(rss_pkg::OP_SKIP_BIT_SET, 8'h08, 3'h2, 8'h00, 8'h00, 0, 0, 4'h9);
		do_op(rss_pkg::OP_SKIP_WHEN_ZERO, 8'h00, 3'h0, 8'h00, 8'h00, 0, 1, 4'h9);
		do_op(rss_pkg::OP_SKIP_WHEN_ZERO, 8'h01, 3'h0, 8'h00, 8'h00, 0, 0, 4'h9);
	endtask

	task automatic t_set();
		do_op(rss_pkg::OP_BYTE_SET, 8'h12, 3'h0, 8'h00, 8'hFF, 1, 0, 4'h9);
		do_op(rss_pkg::OP_BIT_SET, 8'h10, 3'h0, 8'h00, 8'h11, 1, 0, 4'h9);
		do_op(rss_pkg::OP_BIT_SET, 8'h00, 3'h7, 8'h00, 8'h80, 1, 0, 4'h9);
		do_op(rss_pkg::OP_NIBBLE_EXCH, 8'h3C, 3'h0, 8'h00, 8'hC3, 1, 0, 4'h9);
	endtask

	// an issue held through the dummy cycle must be ignored
	task automatic t_refuse();
		@(posedge ref_clk_in);
		op_in <= rss_pkg::OP_SKIP_WHEN_ZERO;
		operand_in <= 8'h00;
		issue_in <= 1'h1;
		@(posedge ref_clk_in);
		op_in <= rss_pkg::OP_BYTE_SET;
		@(posedge ref_clk_in);
		issue_in <= 1'h0;
		#1;
		chk({7'h00, mem_we_out}, 8'h00);
		chk({6'h00, dummy_cycle_out, ready_out}, 8'h01);
		@(posedge ref_clk_in);
		#1;
		chk({7'h00, mem_we_out}, 8'h00);
	endtask

	// ==========================================
	// main sequence
	initial begin
		ref_clk_in = 1'h0;
		rst_in = 1'h1;
		issue_in = 1'h0;
		op_in = rss_pkg::OP_NONE;
		operand_in = 8'h00;
		bit_sel_in = 3'h0;
		error_cnt = 0;
		check_count = 0;
		cycle_cnt = 0;
		repeat (20) @(posedge ref_clk_in);
		rst_in <= 1'h0;
		#1;
		chk(working_register_out, rss_pkg::WORK_RST);
		chk({4'h0, signed_wrap_flag_out, zero_flag_out, half_borrow_flag_out,
			carry_flag_out}, {4'h0, rss_pkg::FLAGS_RST});
		chk({5'h00, mem_we_out, dummy_cycle_out, ready_out}, 8'h01);
		t_rotate();
		t_subtract();
		t_skip();
		t_set();
		t_refuse();
		summarize();
	end
endmodule // tb_top
